// >>> src/lalce_pkg.sv
// constants for the low alarm limit bank and the command echo register
// assumes 8 channels with a five-register stride per channel
package lalce_pkg;
   localparam int LALCE_NUM_CHAN = 8;
   localparam int LALCE_ADDR_BITS = 7;
   localparam int LALCE_WORD_BITS = 16;
   // register addresses
   localparam logic [6:0] LALCE_LOW_UPPER_CH0 = 7'h18;
   localparam logic [6:0] LALCE_LOW_LOWER_CH0 = 7'h19;
   localparam logic [6:0] LALCE_CHAN_STRIDE = 7'h05;
   localparam logic [6:0] LALCE_ECHO_ADDR = 7'h3f;
   // command word fields
   localparam int LALCE_ADDR_MSB = 15;
   localparam int LALCE_ADDR_LSB = 9;
   localparam int LALCE_WRITE_BIT = 8;
   localparam int LALCE_LOWER_LSB = 2;
   // serial frame positions, counted in edges of the serial clock
   localparam logic [4:0] LALCE_ADDR_DONE = 5'h07;
   localparam logic [4:0] LALCE_WORD_DONE = 5'h10;
   localparam logic [4:0] LALCE_ECHO_START = 5'h10;
   localparam logic [4:0] LALCE_ECHO_END = 5'h18;
   localparam logic [4:0] LALCE_CNT_MAX = 5'h1f;
   // values after reset
   localparam logic [7:0] LALCE_UPPER_RST = 8'h00;
   localparam logic [5:0] LALCE_LOWER_RST = 6'h00;
   localparam logic [7:0] LALCE_ECHO_RST = 8'h00;
   localparam logic [7:0] LALCE_TAIL_ZERO = 8'h00;
endpackage : lalce_pkg

// >>> src/lalce_bank.sv
// low alarm limit bank with command echo, reached over the serial port
// assumes serial data is captured on rising and launched on falling serial clock
// edges, and that the frame select is high between frames
`timescale 1ns/1ps
`default_nettype none

module lalce_bank
   import lalce_pkg::*;
(
   // core clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // serial port
   input wire logic serial_clock,
   input wire logic frame_n,
   input wire logic serial_in,
   output logic serial_out_line,
   // conversion results
   input wire logic conv_valid,
   input wire logic [2:0] conv_chan,
   input wire logic [13:0] conv_result,
   // alarm flags
   output logic [LALCE_NUM_CHAN-1:0] low_alarm
);

   // bit position and shifter, cleared while the frame is closed
   typedef struct packed {
      logic [4:0] cnt;
      logic [15:0] shift;
   } lalce_frame_t;

   // captured address and word, kept across frames
   typedef struct packed {
      logic [6:0] addr;
      logic addr_tgl;
      logic [15:0] word;
      logic word_tgl;
   } lalce_rx_t;

   typedef struct packed {
      logic [4:0] fcnt;
      logic [15:0] oshift;
      logic out;
   } lalce_tx_t;

   typedef struct packed {
      logic [LALCE_NUM_CHAN-1:0][7:0] upper;
      logic [LALCE_NUM_CHAN-1:0][5:0] lower;
      logic [7:0] echo;
      logic [7:0] rd_byte;
      logic [2:0] a_sync;
      logic [2:0] w_sync;
      logic [LALCE_NUM_CHAN-1:0] alarm;
   } lalce_core_t;

   lalce_frame_t fr;
   lalce_frame_t next_fr;
   lalce_rx_t rx;
   lalce_rx_t next_rx;
   lalce_tx_t tx;
   lalce_tx_t next_tx;
   lalce_core_t core;
   lalce_core_t next_core;
   logic link_rst_n;
   logic addr_ev;
   logic word_ev;

   // {upper hit, lower hit, channel}
   function automatic logic [4:0] lalce_decode(input logic [6:0] a);
      logic [4:0] d;
      d = 5'h00;
      for (int i = 0; i < LALCE_NUM_CHAN; i++) begin
         if (a == 7'(LALCE_LOW_UPPER_CH0 + LALCE_CHAN_STRIDE * 7'(i))) begin
            d = {2'b10, 3'(i)};
         end
         if (a == 7'(LALCE_LOW_LOWER_CH0 + LALCE_CHAN_STRIDE * 7'(i))) begin
            d = {2'b01, 3'(i)};
         end
      end
      return d;
   endfunction : lalce_decode

   // the link logic only lives while a frame is open
   assign link_rst_n = reset_n & ~frame_n;

   // receive side, rising serial clock
   always_comb begin
      next_fr = fr;
      next_rx = rx;
      next_fr.shift = {fr.shift[14:0], serial_in};
      if (fr.cnt != LALCE_CNT_MAX) begin
         next_fr.cnt = fr.cnt + 5'h01;
      end
      if (fr.cnt == LALCE_ADDR_DONE - 5'h01) begin
         next_rx.addr = {fr.shift[5:0], serial_in};
         next_rx.addr_tgl = ~rx.addr_tgl;
      end
      if (fr.cnt == LALCE_WORD_DONE - 5'h01) begin
         next_rx.word = {fr.shift[14:0], serial_in};
         next_rx.word_tgl = ~rx.word_tgl;
      end
   end

   always_ff @(posedge serial_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
         fr <= '0;
      end else begin
         fr <= next_fr;
      end
   end

   // toggles persist across frames so the core never sees a false event
   always_ff @(posedge serial_clock or negedge reset_n) begin
      if (!reset_n) begin
         rx <= '0;
      end else begin
         rx <= next_rx;
      end
   end

   // transmit side, falling serial clock
   always_comb begin
      next_tx = tx;
      if (tx.fcnt != LALCE_CNT_MAX) begin
         next_tx.fcnt = tx.fcnt + 5'h01;
      end
      if (tx.fcnt == LALCE_ECHO_START - 5'h01) begin
         next_tx.oshift = {core.rd_byte[6:0], LALCE_TAIL_ZERO, 1'b0};
         next_tx.out = core.rd_byte[7];
      end else if (tx.fcnt >= LALCE_ECHO_START) begin
         next_tx.oshift = {tx.oshift[14:0], 1'b0};
         next_tx.out = tx.oshift[15];
      end
   end

   always_ff @(negedge serial_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx <= '0;
      end else begin
         tx <= next_tx;
      end
   end

   assign serial_out_line = tx.out;

   // rd_byte is settled nine serial clocks before edge 16 takes it;
   // this timing margin stands in for a return handshake
   assign addr_ev = core.a_sync[2] ^ core.a_sync[1];
   assign word_ev = core.w_sync[2] ^ core.w_sync[1];

   always_comb begin
      logic [4:0] d;
      logic [4:0] dw;
      logic [13:0] limit;
      d = lalce_decode(rx.addr);
      dw = lalce_decode(rx.word[LALCE_ADDR_MSB:LALCE_ADDR_LSB]);
      limit = 14'h0000;
      next_core = core;
      next_core.a_sync = {core.a_sync[1:0], rx.addr_tgl};
      next_core.w_sync = {core.w_sync[1:0], rx.word_tgl};
      if (addr_ev) begin
         if (d[4]) begin
            next_core.rd_byte = core.upper[d[2:0]];
         end else if (d[3]) begin
            next_core.rd_byte = {core.lower[d[2:0]], 2'b00};
         end else if (rx.addr == LALCE_ECHO_ADDR) begin
            next_core.rd_byte = core.echo;
         end else begin
            next_core.rd_byte = 8'h00;
         end
      end
      if (word_ev) begin
         if (rx.word[LALCE_WRITE_BIT] && dw[4]) begin
            next_core.upper[dw[2:0]] = rx.word[7:0];
         end
         if (rx.word[LALCE_WRITE_BIT] && dw[3]) begin
            next_core.lower[dw[2:0]] = rx.word[7:LALCE_LOWER_LSB];
         end
         next_core.echo = rx.word[15:8];
      end
      if (conv_valid) begin
         limit = {core.upper[conv_chan], core.lower[conv_chan]};
         next_core.alarm[conv_chan] = conv_result < limit;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < LALCE_NUM_CHAN; i++) begin
            core.upper[i] <= LALCE_UPPER_RST;
            core.lower[i] <= LALCE_LOWER_RST;
         end
         core.echo <= LALCE_ECHO_RST;
         core.rd_byte <= 8'h00;
         core.a_sync <= 3'h0;
         core.w_sync <= 3'h0;
         core.alarm <= '0;
      end else begin
         core <= next_core;
      end
   end

   assign low_alarm = core.alarm;

   // core-domain checks
   chk_upper_write: assert property (@(posedge clock) disable iff (!reset_n)
      (word_ev && rx.word[8] && rx.word[15:9] == LALCE_LOW_UPPER_CH0)
      |=> core.upper[0] == $past(rx.word[7:0]))
      else $error("upper byte write lost");

   chk_lower_write: assert property (@(posedge clock) disable iff (!reset_n)
      (word_ev && rx.word[8] && rx.word[15:9] == LALCE_LOW_LOWER_CH0)
      |=> core.lower[0] == $past(rx.word[7:2]))
      else $error("lower field write lost");

   chk_lower_zero: assert property (@(posedge clock) disable iff (!reset_n)
      (addr_ev && rx.addr == LALCE_LOW_LOWER_CH0) |=> core.rd_byte[1:0] == 2'b00)
      else $error("lower read shows nonzero low bits");

   chk_lower_read: assert property (@(posedge clock) disable iff (!reset_n)
      (addr_ev && rx.addr == LALCE_LOW_LOWER_CH0) |=> core.rd_byte[7:2] == $past(core.lower[0]))
      else $error("lower field read wrong");

   chk_upper_read: assert property (@(posedge clock) disable iff (!reset_n)
      (addr_ev && rx.addr == LALCE_LOW_UPPER_CH0) |=> core.rd_byte == $past(core.upper[0]))
      else $error("upper byte read wrong");

   chk_echo_read: assert property (@(posedge clock) disable iff (!reset_n)
      (addr_ev && rx.addr == LALCE_ECHO_ADDR) |=> core.rd_byte == $past(core.echo))
      else $error("echo read wrong");

   chk_echo_update: assert property (@(posedge clock) disable iff (!reset_n)
      word_ev |=> core.echo == $past(rx.word[15:8]))
      else $error("echo not updated from frame");

   chk_echo_hold: assert property (@(posedge clock) disable iff (!reset_n)
      !word_ev |=> $stable(core.echo))
      else $error("echo changed without a frame");

   // any channel, both outcomes of the compare
   chk_alarm_cmp: assert property (@(posedge clock) disable iff (!reset_n)
      conv_valid |=> low_alarm[$past(conv_chan)] ==
      ($past(conv_result) < $past({core.upper[conv_chan], core.lower[conv_chan]})))
      else $error("low alarm compare wrong");

   chk_alarm_hold: assert property (@(posedge clock) disable iff (!reset_n)
      !conv_valid |=> $stable(low_alarm))
      else $error("low alarm changed without a result");

   // link-domain checks
   chk_early_quiet: assert property (@(negedge serial_clock) disable iff (!link_rst_n)
      (tx.fcnt < LALCE_ECHO_START) |-> !serial_out_line)
      else $error("output active before edge 16");

   chk_echo_msb: assert property (@(negedge serial_clock) disable iff (!link_rst_n)
      (tx.fcnt == LALCE_ECHO_START - 5'h01) |=> serial_out_line == core.rd_byte[7])
      else $error("echo msb not first");

   chk_tail_zero: assert property (@(negedge serial_clock) disable iff (!link_rst_n)
      (tx.fcnt >= LALCE_ECHO_END) |-> !serial_out_line)
      else $error("echo tail not zero");

   cov_write: cover property (@(posedge clock) disable iff (!reset_n)
      word_ev && rx.word[8]);
   cov_echo: cover property (@(posedge clock) disable iff (!reset_n)
      addr_ev && rx.addr == LALCE_ECHO_ADDR);
   cov_alarm: cover property (@(posedge clock) disable iff (!reset_n)
      conv_valid ##1 |low_alarm);
   cov_lower_read: cover property (@(posedge clock) disable iff (!reset_n)
      addr_ev && rx.addr == LALCE_LOW_LOWER_CH0);
   cov_echo_tail: cover property (@(negedge serial_clock) disable iff (!link_rst_n)
      tx.fcnt == LALCE_ECHO_END);

endmodule : lalce_bank

`default_nettype wire

// >>> tb/lalce_host.sv
// host model: runs frames on the serial port of the limit bank
// assumes read data is launched on falling serial clock edges
`timescale 1ns/1ps
`default_nettype none
module lalce_host (
   // serial port
   output logic serial_clock,
   output logic frame_n,
   output logic serial_in,
   input wire logic serial_out_line
);
   initial begin
      serial_clock = 1'b0;
      frame_n = 1'b1;
      serial_in = 1'b1;
   end
   // serial clock stands still between frames
   task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd,
      output logic [7:0] tail);
      logic [31:0] sh;
      logic [15:0] got;
      sh = {word, 16'h0000};
      got = 16'h0000;
      frame_n = 1'b0;
      #40;
      for (int i = 1; i <= nbits; i++) begin
         serial_in = sh[31];
         sh = sh << 1;
         #80;
         serial_clock = 1'b1;
         if (i > 16) begin
            got = {got[14:0], serial_out_line};
         end
         #80;
         serial_clock = 1'b0;
      end
      // echo frame may stop at 24
      rd = (nbits > 24) ? got[15:8] : got[7:0];
      tail = got[7:0];
      #40;
      frame_n = 1'b1;
      // released data line shows the inverse, not a stale bit
      serial_in = ~serial_in;
      #400;
   endtask : xfer
endmodule : lalce_host
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the low alarm limit bank
// assumes the host model drives the serial port in its own time base
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import lalce_pkg::*;
   logic clock, reset_n, conv_valid;
   logic [2:0] conv_chan;
   logic [13:0] conv_result;
   wire logic serial_clock, frame_n, serial_in, serial_out_line;
   wire logic [LALCE_NUM_CHAN-1:0] low_alarm;
   int mismatches = 0;
   int compares = 0;
   logic [7:0] rd, tl;
   lalce_bank dut (.clock(clock), .reset_n(reset_n), .serial_clock(serial_clock),
      .frame_n(frame_n), .serial_in(serial_in), .serial_out_line(serial_out_line),
      .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_result(conv_result),
      .low_alarm(low_alarm));
   lalce_host host (.serial_clock(serial_clock), .frame_n(frame_n), .serial_in(serial_in),
      .serial_out_line(serial_out_line));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic rw(input logic [6:0] a, input logic w, input logic [7:0] d, input int n);
      host.xfer({a, w, d}, n, rd, tl);
   endtask : rw
   task automatic t_reset;
      rw(LALCE_ECHO_ADDR, 1'b0, 8'h00, 24);
      check("echo after reset", LALCE_ECHO_RST, rd);
      rw(LALCE_LOW_UPPER_CH0, 1'b0, 8'h00, 24);
      check("upper after reset", LALCE_UPPER_RST, rd);
      rw(LALCE_LOW_LOWER_CH0, 1'b0, 8'h00, 24);
      check("lower after reset", 8'h00, rd);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_limits;
      logic [6:0] a;
      for (int n = 0; n < 8; n++) begin
         a = LALCE_LOW_UPPER_CH0 + LALCE_CHAN_STRIDE * 7'(n);
         rw(a, 1'b1, 8'h5a ^ 8'(n * 17), 16);
         rw(a + 7'h01, 1'b1, 8'hff ^ 8'(n), 16);
      end
      for (int n = 0; n < 8; n++) begin
         a = LALCE_LOW_UPPER_CH0 + LALCE_CHAN_STRIDE * 7'(n);
         rw(a, 1'b0, 8'h00, 24);
         check("upper readback", 8'h5a ^ 8'(n * 17), rd);
         rw(a + 7'h01, 1'b0, 8'h00, 24);
         check("lower readback", (8'hff ^ 8'(n)) & 8'hfc, rd);
      end
      rw(LALCE_ECHO_ADDR, 1'b1, 8'hff, 16);
      rw(LALCE_ECHO_ADDR, 1'b0, 8'h00, 24);
      check("echo after write", 8'h7f, rd);
      $display("t_limits done");
   endtask : t_limits
   task automatic t_echo;
      rw(7'h27, 1'b1, 8'h33, 16);
      rw(LALCE_ECHO_ADDR, 1'b0, 8'h00, 32);
      check("echo byte", 8'h4f, rd);
      check("echo tail", LALCE_TAIL_ZERO, tl);
      rw(LALCE_ECHO_ADDR, 1'b0, 8'h00, 24);
      check("echo of echo", 8'h7e, rd);
      rw(7'h70, 1'b0, 8'h00, 24);
      check("unmapped read", 8'h00, rd);
      $display("t_echo done");
   endtask : t_echo
   task automatic t_alarm;
      logic [13:0] lim;
      lim = {8'h78, 6'h3f};
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         conv_valid <= 1'b1;
         conv_chan <= 3'h2;
         conv_result <= lim - 14'(1 - k);
         @(posedge clock);
         conv_valid <= 1'b0;
         repeat (2) @(posedge clock);
         check("low alarm ch2", {7'h00, k == 0}, {7'h00, low_alarm[2]});
      end
      $display("t_alarm done");
   endtask : t_alarm
   initial begin
      reset_n = 1'b0;
      conv_valid = 1'b0;
      conv_chan = 3'h0;
      conv_result = 14'h0000;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      repeat (2) @(posedge clock);
      t_reset();
      t_limits();
      t_echo();
      t_alarm();
      give_verdict();
   end
   initial begin
      #400000;
      mismatches++;
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
